// file: wdt_regs.svh
// Purpose: Offsets, field positions, reset values and timing of the watchdog
// Assumes: 8-bit special-function-register space, 100 MHz system clock
// Notes:   Definitions only
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

`define WDT_ADDR_PWR_FLAGS   8'h97
`define WDT_ADDR_CONTROL     8'hE1

`define WDT_BIT_RESET_EN     7
`define WDT_BIT_RUN_PD       6
`define WDT_BIT_RUN_EN       5
`define WDT_BIT_CLEAR        4
`define WDT_BIT_RUN_IDLE     3
`define WDT_BIT_PS_HI        2
`define WDT_BIT_PS_LO        0
`define WDT_BIT_OVF_FLAG     0

`define WDT_CONTROL_RESET    8'h00

`define WDT_CNT_WIDTH        9
`define WDT_PRE_WIDTH        7
`define WDT_CNT_MAX          9'h1FF

`define WDT_SYS_CLK_HZ       100000000
`define WDT_RC_OSC_HZ        32000
`define WDT_SYNC_STAGES      2

`endif

// file: wdt_pkg.sv
// Purpose: Types shared by the watchdog files
// Assumes: Included constants header
// Notes:   Fields carried as packed structs
package wdt_pkg;

  // Control fields held in the control register
  typedef struct packed {
    logic       reset_en;
    logic       run_pd;
    logic       run_en;
    logic       run_idle;
    logic [2:0] prescale_sel;
  } wdt_ctrl_t;

  // Fuse options presented by the option block
  typedef struct packed {
    logic       auto_enable;
    logic       write_protect;
    logic       reset_en;
    logic       run_pd;
    logic       run_idle;
    logic [2:0] prescale_sel;
  } wdt_fuse_t;

  // One register access from the processor
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       page_p;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdt_sfr_req_t;

  // Start-up sequence after power-on reset
  typedef enum logic [1:0] {
    WDT_ST_WAIT = 2'b00,
    WDT_ST_LOAD = 2'b01,
    WDT_ST_RUN  = 2'b10
  } wdt_init_t;

endpackage

// file: wdt_sync.sv
// Purpose: Two-stage synchroniser for inputs from outside the clock domain
// Assumes: Inputs change slowly relative to clk
// Notes:   Stage one feeds only stage two
`timescale 1ns/1ps
module wdt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // System clock
  input  wire logic             arst_n, // Power-on reset, active low
  input  wire logic             ce,     // Clock enable
  input  wire logic [WIDTH-1:0] d,      // Asynchronous input
  output logic      [WIDTH-1:0] q       // Synchronised output
);

  logic [WIDTH-1:0] meta_q;

  // Two flops in series
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// file: wdt_core.sv
// Purpose: Watchdog timer with fuse initialisation and write protection
// Assumes: arst_n is the power-on reset; soft_rst covers other resets
// Notes:   Registers reached through the processor SFR access port
`timescale 1ns/1ps
`include "wdt_regs.svh"

module wdt_core
  import wdt_pkg::*;
#(
  parameter int CNT_W = `WDT_CNT_WIDTH,
  parameter int PRE_W = `WDT_PRE_WIDTH
) (
  input  wire logic         clk,              // System clock, 100 MHz
  input  wire logic         arst_n,           // Power-on reset, active low
  input  wire logic         ce,               // Clock enable, freezes state
  input  wire logic         soft_rst,         // Pin, software, watchdog reset
  input  wire wdt_sfr_req_t sfr,              // Register access request
  input  wire logic         low_speed_rc_osc, // 32 kHz oscillator input
  input  wire wdt_fuse_t    fuse,             // Fuse options
  input  wire logic         cpu_idle,         // Processor in idle mode
  input  wire logic         cpu_powerdown,    // Processor in power-down
  output logic      [7:0]   sfr_rdata_q,      // Registered read data
  output logic              overflow_flag_q,  // Sticky overflow flag
  output logic              wdt_reset_q,      // System reset pulse
  output logic              wdt_running_q     // Counter is advancing
);

  // Refuse shapes the logic cannot serve
  if (CNT_W != `WDT_CNT_WIDTH || PRE_W != `WDT_PRE_WIDTH) begin : g_chk
    $error("wdt_core supports only a 9-bit counter and 7-bit prescaler");
  end

  localparam int SYNC_W = $bits(wdt_fuse_t) + 1;

  // Power-on value of the stored control bits; bit 4 is a strobe only
  localparam logic [7:0] CTRL_POR  = `WDT_CONTROL_RESET;
  localparam wdt_ctrl_t  CTRL_INIT = {
    CTRL_POR[`WDT_BIT_RESET_EN:`WDT_BIT_RUN_EN],
    CTRL_POR[`WDT_BIT_RUN_IDLE:`WDT_BIT_PS_LO]};

  wdt_ctrl_t        ctrl_q, ctrl_d;
  wdt_init_t        init_q, init_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic             rc_prev_q;
  logic             settle_q;
  logic             flag_d;
  logic [SYNC_W-1:0] sync_out;
  wdt_fuse_t        fuse_s;
  logic             rc_s;

  // Fuses and oscillator come from outside the clock domain
  wdt_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .d      ({fuse, low_speed_rc_osc}),
    .q      (sync_out)
  );

  assign fuse_s = wdt_fuse_t'(sync_out[SYNC_W-1:1]);
  assign rc_s   = sync_out[0];

  // Register decode
  wire hit_ctrl  = sfr.addr == `WDT_ADDR_CONTROL;
  wire hit_flags = sfr.addr == `WDT_ADDR_PWR_FLAGS;
  wire wr_ctrl   = sfr.wr && hit_ctrl && (init_q == WDT_ST_RUN);
  wire wr_flags  = sfr.wr && hit_flags;
  wire clr_cnt   = wr_ctrl && sfr.wdata[`WDT_BIT_CLEAR];
  wire lock_all  = fuse_s.auto_enable && fuse_s.write_protect;
  wire lock_cfg  = fuse_s.write_protect;
  wire cfg_wr    = wr_ctrl && !lock_all;

  // Enable bits: page-P writes freely, normal pages only set
  wire [2:0] en_old = {ctrl_q.reset_en, ctrl_q.run_pd, ctrl_q.run_en};
  wire [2:0] en_wd  = sfr.wdata[`WDT_BIT_RESET_EN:`WDT_BIT_RUN_EN];
  wire [2:0] en_new = sfr.page_p ? en_wd : (en_old | en_wd);

  // Run conditions per processor mode
  wire idle_ok = ctrl_q.run_idle || ctrl_q.run_pd
               || fuse_s.run_pd;
  wire mode_ok = cpu_powerdown ? ctrl_q.run_pd
               : (cpu_idle ? idle_ok : 1'b1);
  wire running = ctrl_q.run_en && mode_ok;

  // Prescaler tap chosen by prescale_sel
  wire             rc_tick  = rc_s && !rc_prev_q;
  wire [7:0]       mask_w   = (8'h01 << ctrl_q.prescale_sel) - 8'h01;
  wire [PRE_W-1:0] pre_mask = mask_w[PRE_W-1:0];
  wire             base_tk  = running && rc_tick;
  wire             pre_tk   = base_tk
                            && ((pre_q & pre_mask) == pre_mask);
  wire             ovf      = pre_tk && (cnt_q == `WDT_CNT_MAX)
                            && !clr_cnt;

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    init_d = init_q;
    case (init_q)
      WDT_ST_WAIT: begin
        // Hold one more edge so the fuse synchroniser has settled
        if (settle_q) begin
          init_d = WDT_ST_LOAD;
        end
      end
      WDT_ST_LOAD: begin
        init_d = WDT_ST_RUN;
        if (fuse_s.auto_enable) begin
          ctrl_d.run_en       = 1'b1;
          ctrl_d.reset_en     = fuse_s.reset_en;
          ctrl_d.run_pd       = fuse_s.run_pd;
          ctrl_d.run_idle     = fuse_s.run_idle;
          ctrl_d.prescale_sel = fuse_s.prescale_sel;
        end
      end
      WDT_ST_RUN: begin
        if (cfg_wr) begin
          ctrl_d.run_en = en_new[0];
          if (!lock_cfg) begin
            ctrl_d.reset_en     = en_new[2];
            ctrl_d.run_pd       = en_new[1];
            ctrl_d.run_idle     = sfr.wdata[`WDT_BIT_RUN_IDLE];
            ctrl_d.prescale_sel =
              sfr.wdata[`WDT_BIT_PS_HI:`WDT_BIT_PS_LO];
          end
        end
      end
      default: begin
        init_d = WDT_ST_WAIT;
      end
    endcase
  end

  // Counter and prescaler next value
  always_comb begin
    cnt_d = cnt_q;
    pre_d = pre_q;
    if (soft_rst || clr_cnt) begin
      cnt_d = '0;
      pre_d = '0;
    end else begin
      if (base_tk) begin
        pre_d = pre_q + 1'b1;
      end
      if (pre_tk) begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Flag: a new overflow wins over a software clear
  always_comb begin
    flag_d = overflow_flag_q;
    if (wr_flags && sfr.wdata[`WDT_BIT_OVF_FLAG]) begin
      flag_d = 1'b0;
    end
    if (ovf) begin
      flag_d = 1'b1;
    end
  end

  // Read data multiplexer
  wire [7:0] ctrl_rd = {ctrl_q.reset_en, ctrl_q.run_pd, ctrl_q.run_en,
                        1'b0, ctrl_q.run_idle, ctrl_q.prescale_sel};
  wire [7:0] rd_mux  = hit_ctrl  ? ctrl_rd
                     : hit_flags ? {7'h00, overflow_flag_q}
                     : 8'h00;

  // Control state only returns to default on power-on reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q   <= CTRL_INIT;
      init_q   <= WDT_ST_WAIT;
      settle_q <= 1'b0;
    end else if (ce) begin
      ctrl_q   <= ctrl_d;
      init_q   <= init_d;
      settle_q <= 1'b1;
    end
  end

  // Counting state and outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q           <= '0;
      pre_q           <= '0;
      rc_prev_q       <= 1'b0;
      overflow_flag_q <= 1'b0;
      wdt_reset_q     <= 1'b0;
      wdt_running_q   <= 1'b0;
      sfr_rdata_q     <= 8'h00;
    end else if (ce) begin
      cnt_q           <= cnt_d;
      pre_q           <= pre_d;
      rc_prev_q       <= rc_s;
      overflow_flag_q <= flag_d;
      wdt_reset_q     <= ovf && ctrl_q.reset_en;
      wdt_running_q   <= running;
      if (sfr.rd) begin
        sfr_rdata_q <= rd_mux;
      end
    end
  end

endmodule

// file: wdt_core_asserts.sv
// Purpose: Port checks for the watchdog core
// Assumes: One clock, arst_n is power-on reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`include "wdt_regs.svh"
module wdt_core_asserts
  import wdt_pkg::*;
(
  input wire logic         clk,             // Clock
  input wire logic         arst_n,          // Reset, low
  input wire logic         ce,              // Enable
  input wire logic         soft_rst,        // Other resets
  input wire wdt_sfr_req_t sfr,             // Access
  input wire logic [7:0]   sfr_rdata_q,     // Read data
  input wire logic         overflow_flag_q, // Flag
  input wire logic         wdt_reset_q,     // Reset pulse
  input wire logic         wdt_running_q    // Counting
);
  logic [1:0] por_q; // Edges since reset
  // Decoded accesses
  wire rd_c = sfr.rd && ce && sfr.addr == `WDT_ADDR_CONTROL;
  wire rd_f = sfr.rd && ce && sfr.addr == `WDT_ADDR_PWR_FLAGS;
  wire wr_c = sfr.wr && ce && sfr.addr == `WDT_ADDR_CONTROL;
  wire wr_f = sfr.wr && ce && sfr.addr == `WDT_ADDR_PWR_FLAGS;
  // Count first edges after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) por_q <= 2'h0;
    else if (por_q != 2'h3) por_q <= por_q + 2'h1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_quiet_after_por: assert property (por_q < 2'h2 |-> !wdt_running_q)
    else $error("running too soon");
  a_reset_pulse_gap: assert property (wdt_reset_q |=> (!wdt_reset_q) [*8])
    else $error("reset pulse too long");
  a_reset_with_flag: assert property (wdt_reset_q |-> overflow_flag_q)
    else $error("reset without flag");
  a_flag_zero_write: assert property (wr_f && !sfr.wdata[0] &&
    overflow_flag_q |=> overflow_flag_q)
    else $error("flag lost on zero write");
  a_flag_rise_run: assert property ($rose(overflow_flag_q) |->
    $past(wdt_running_q))
    else $error("flag set while idle");
  a_clear_reads_zero: assert property (rd_c |=> !sfr_rdata_q[4])
    else $error("clear bit reads one");
  a_flags_read_upper: assert property (rd_f |=> sfr_rdata_q[7:1] == 7'h00)
    else $error("flag read upper bits");
  a_clear_no_ovf: assert property (wr_c && sfr.wdata[4] |=>
    (!$rose(overflow_flag_q) && !wdt_reset_q) [*8])
    else $error("overflow after clear");
  a_soft_keeps_flag: assert property (soft_rst && overflow_flag_q && !wr_f
    |=> overflow_flag_q)
    else $error("flag lost on soft reset");
  c_ovf: cover property ($rose(overflow_flag_q));
  c_rst: cover property (wdt_reset_q);
  c_pp: cover property (wr_c && sfr.page_p);
endmodule

// file: wdt_core_tb.sv
// Purpose: Self-checking bench for the watchdog core
// Assumes: Oscillator driven fast, ce dropped in one scenario
// Notes:   One task per scenario
`timescale 1ns/1ps
`include "wdt_regs.svh"
module wdt_core_tb
  import wdt_pkg::*;
;
  logic         clk, arst_n, ce, soft_rst, osc, idle, pd, flag, rst_p, run;
  wdt_sfr_req_t sfr;
  wdt_fuse_t    fuse;
  logic [7:0]   rdata;
  logic [10:0]  modes [6] = '{11'h184, 11'h1C5, 11'h1C2, 11'h383,
                              11'h385, 11'h181};
  int           err_count, checks_done, n;
  wdt_core uut (.clk(clk), .arst_n(arst_n), .ce(ce), .soft_rst(soft_rst),
    .sfr(sfr), .low_speed_rc_osc(osc), .fuse(fuse), .cpu_idle(idle),
    .cpu_powerdown(pd), .sfr_rdata_q(rdata), .overflow_flag_q(flag),
    .wdt_reset_q(rst_p), .wdt_running_q(run));
  // Clock and fast oscillator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) osc <= ~osc;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One register access, strobe held one cycle
  task automatic acc(input logic w, p, input logic [7:0] a, d);
    @(posedge clk);
    sfr <= '{w, !w, p, a, d};
    @(posedge clk);
    sfr <= '0;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    acc(1'b0, 1'b0, a, 8'h00);
    #1 chk(rdata, e);
  endtask
  task automatic por(input wdt_fuse_t f);
    @(posedge clk);
    arst_n <= 1'b0;
    fuse <= f;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic ovf_wait();
    n = 0;
    while (flag !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_set_only();
    acc(1, 0, `WDT_ADDR_CONTROL, 8'h35);
    rdc(`WDT_ADDR_CONTROL, 8'h25);
    acc(1, 0, `WDT_ADDR_CONTROL, 8'h00);
    rdc(`WDT_ADDR_CONTROL, 8'h20);
    acc(1, 0, `WDT_ADDR_CONTROL, 8'hC8);
    rdc(`WDT_ADDR_CONTROL, 8'hE8);
    acc(1, 1, `WDT_ADDR_CONTROL, 8'h00);
    rdc(`WDT_ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_period();
    for (int ps = 0; ps < 2; ps++) begin
      acc(1, 1, `WDT_ADDR_CONTROL, 8'h30 | 8'(ps));
      ovf_wait();
      chk(8'(n > (1024 << ps) - 9 && n < (1024 << ps) + 9), 8'h01);
      chk(8'(rst_p), 8'h00);
      acc(1, 0, `WDT_ADDR_PWR_FLAGS, 8'h00);
      rdc(`WDT_ADDR_PWR_FLAGS, 8'h01);
      acc(1, 0, `WDT_ADDR_PWR_FLAGS, 8'h01);
      rdc(`WDT_ADDR_PWR_FLAGS, 8'h00);
    end
  endtask
  task automatic t_reset_en();
    acc(1, 1, `WDT_ADDR_CONTROL, 8'hB0);
    ovf_wait();
    chk(8'(rst_p), 8'h01);
    @(negedge clk) chk(8'(rst_p), 8'h00);
    @(posedge clk) soft_rst <= 1'b1;
    @(posedge clk) soft_rst <= 1'b0;
    rdc(`WDT_ADDR_CONTROL, 8'hA0);
    rdc(`WDT_ADDR_PWR_FLAGS, 8'h01);
  endtask
  // Clearing in time keeps overflow away
  task automatic t_clear();
    acc(1, 0, `WDT_ADDR_PWR_FLAGS, 8'h01);
    acc(1, 1, `WDT_ADDR_CONTROL, 8'h30);
    repeat (3) begin
      repeat (700) @(posedge clk);
      acc(1, 0, `WDT_ADDR_CONTROL, 8'h30);
    end
    rdc(`WDT_ADDR_PWR_FLAGS, 8'h00);
  endtask
  task automatic t_modes();
    foreach (modes[i]) begin
      acc(1, 1, `WDT_ADDR_CONTROL, modes[i][10:3]);
      @(posedge clk) {idle, pd} <= modes[i][2:1];
      repeat (3) @(posedge clk);
      @(negedge clk) chk(8'(run), 8'(modes[i][0]));
    end
    @(posedge clk) {idle, pd} <= 2'b00;
  endtask
  task automatic t_fuse();
    por(8'hAB);
    rdc(`WDT_ADDR_CONTROL, 8'hAB);
    acc(1, 1, `WDT_ADDR_CONTROL, 8'h00);
    rdc(`WDT_ADDR_CONTROL, 8'h00);
    por(8'hEB);
    acc(1, 1, `WDT_ADDR_CONTROL, 8'h00);
    rdc(`WDT_ADDR_CONTROL, 8'hAB);
    por(8'h40);
    acc(1, 0, `WDT_ADDR_CONTROL, 8'hFF);
    rdc(`WDT_ADDR_CONTROL, 8'h20);
    por(8'h10);
    acc(1, 0, `WDT_ADDR_CONTROL, 8'h30);
    @(posedge clk) idle <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk) chk(8'(run), 8'h01);
  endtask
  // A write while ce is low must not land
  task automatic t_freeze();
    acc(1, 1, `WDT_ADDR_CONTROL, 8'h30);
    @(posedge clk) ce <= 1'b0;
    acc(1, 1, `WDT_ADDR_CONTROL, 8'h00);
    @(posedge clk) ce <= 1'b1;
    rdc(`WDT_ADDR_CONTROL, 8'h20);
  endtask
  // Watchdog against a hang
  initial begin
    #300000;
    err_count++;
    give_verdict();
  end
  initial begin
    {arst_n, soft_rst, osc, idle, pd} = '0;
    ce = 1'b1;
    sfr = '0;
    fuse = '0;
    err_count = 0;
    checks_done = 0;
    por(8'h00);
    rdc(`WDT_ADDR_CONTROL, 8'h00);
    rdc(8'h55, 8'h00);
    t_set_only();
    t_period();
    t_reset_en();
    t_clear();
    t_modes();
    t_freeze();
    t_fuse();
    give_verdict();
  end
endmodule
bind wdt_core wdt_core_asserts chk_i (.clk(clk), .arst_n(arst_n), .ce(ce),
  .soft_rst(soft_rst), .sfr(sfr), .sfr_rdata_q(sfr_rdata_q),
  .overflow_flag_q(overflow_flag_q), .wdt_reset_q(wdt_reset_q),
  .wdt_running_q(wdt_running_q));
